// ==== test/tcas_plug_model.sv ====
module tcas_plug_model (
    input  wire logic clk_i,
    output logic       cc_o,
    output logic       plug_o,
    output logic       smo_o,
    output logic [7:0] code_o,
    output logic       cval_o,
    output logic [7:0] stat_o,
    output logic       irqe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {cc_o, plug_o, smo_o, cval_o, irqe_o} = 5'h04;
        code_o = 8'h00;
        stat_o = 8'h00;
    end
    task automatic orient(input logic p, input logic s);
        @(posedge clk_i);
        plug_o <= p;
        smo_o <= s;
    endtask
    // code lines carry the inverse once valid drops, never a stale copy
    task automatic measure(input logic [7:0] c);
        @(posedge clk_i);
        code_o <= c;
        cval_o <= 1'b1;
        irqe_o <= 1'b1;
        @(posedge clk_i);
        code_o <= ~c;
        cval_o <= 1'b0;
        irqe_o <= 1'b0;
    endtask
    task automatic status(input logic [7:0] v);
        @(posedge clk_i);
        stat_o <= v;
    endtask
    task automatic unplug();
        @(posedge clk_i);
        cc_o <= 1'b1;
    endtask
endmodule

// ==== test/tcas_router_bench.sv ====
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module tcas_router_bench
    import tcas_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, cc, plug, smo, cval, irqe;
    logic [7:0] addr = 8'h00, code, stat, rq;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] be = 4'h1;
    logic [1:0] resp, rr;
    logic wreq, lowc, rstp, irqn, irqoe, irqoe_s;
    tcas_sw_s sw, sw_s;
    int mismatches = 0, n_checks = 0, cyc = 0;
    logic [2:0] rt_tab [9] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h6, 3'h7, 3'h7};
    logic [8:0] or_bits = 9'h150;
    logic [15:0] ex_s_tab [9] = '{16'h0000, 16'h8909, 16'h0000, 16'h8009, 16'h4006,
                                  16'h3910, 16'h3640, 16'h3910, 16'h3640};
    logic [15:0] ex_tab [9] = '{16'h0000, 16'hc930, 16'hc6c0, 16'hc060, 16'hc000,
                                16'h3930, 16'h36c0, 16'h3920, 16'h3680};
    always #12.5 clk_i = ~clk_i;
    tcas_router #(.SINGLE_SENSE(1'b0), .BBM_CYC(4), .DISCH_CYC(8)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .avs_response_o(resp),
        .cc_high_i(cc), .plug_orientation_flag_i(plug), .sm_orientation_i(smo),
        .impedance_code_i(code), .impedance_valid_i(cval), .status_event_i(stat),
        .irq_event_i(irqe), .switch_o(sw), .low_current_o(lowc), .sm_restart_o(rstp),
        .irq_n_o(irqn), .irq_n_oe_o(irqoe));
    // single-sense variant shares every input; bus timing is the same as DUT's
    tcas_router #(.SINGLE_SENSE(1'b1), .BBM_CYC(4), .DISCH_CYC(8)) DUT_S (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(), .avs_waitrequest_o(), .avs_response_o(),
        .cc_high_i(cc), .plug_orientation_flag_i(plug), .sm_orientation_i(smo),
        .impedance_code_i(code), .impedance_valid_i(cval), .status_event_i(stat),
        .irq_event_i(irqe), .switch_o(sw_s), .low_current_o(), .sm_restart_o(),
        .irq_n_o(), .irq_n_oe_o(irqoe_s));
    tcas_plug_model m (.clk_i(clk_i), .cc_o(cc), .plug_o(plug), .smo_o(smo), .code_o(code),
        .cval_o(cval), .stat_o(stat), .irqe_o(irqe));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // a hung handshake is cut short by the cycle ceiling, not here
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] e);
        @(posedge clk_i);
        addr <= a;
        wdata <= {24'h0, d};
        be <= e;
        wr <= w;
        rd <= !w;
        do @(posedge clk_i); while (wreq !== 1'b0);
        rq = rdata[7:0];
        rr = resp;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic settle();
        repeat (20) @(posedge clk_i);
    endtask
    task automatic t_reset();
        bus(1'b0, 8'h18, 8'h00, 4'h1);
        `CHK("ctrl", 8'h10, rq)
        bus(1'b0, 8'h1c, 8'h00, 4'h1);
        `CHK("detcfg", 8'h0c, rq)
        bus(1'b0, 8'h00, 8'h00, 4'h1);
        `CHK("resp", 2'h2, rr)
        `CHK("switch", 16'h0000, sw)
        `CHK("irq_oe", 1'h0, irqoe)
        `CHK("irq_n", 1'h0, irqn)
        `CHK("switch_s", 16'h0000, sw_s)
    endtask
    task automatic t_routes();
        bus(1'b1, 8'h1c, 8'h0e, 4'h1);
        for (int i = 0; i < 9; i++) begin
            m.orient(or_bits[i], !or_bits[i]);
            bus(1'b1, 8'h18, {5'h02, rt_tab[i]}, 4'h1);
            settle();
            `CHK("route", ex_tab[i], sw)
            `CHK("route_s", ex_s_tab[i], sw_s)
        end
    endtask
    task automatic t_sm_orient();
        bus(1'b1, 8'h1c, 8'h0c, 4'h1);
        m.orient(1'b0, 1'b1);
        bus(1'b1, 8'h18, 8'h16, 4'h1);
        settle();
        `CHK("sm_orient", 16'h36c0, sw)
        `CHK("sm_orient_s", 16'h3640, sw_s)
    endtask
    task automatic t_manual();
        bus(1'b1, 8'h34, 8'h5a, 4'h1);
        bus(1'b1, 8'h38, 8'ha5, 4'h1);
        bus(1'b1, 8'h34, 8'hff, 4'h0);
        bus(1'b1, 8'h18, 8'h13, 4'h1);
        settle();
        `CHK("manual", 16'ha55a, sw)
        `CHK("manual_s", 16'h0000, sw_s)
    endtask
    task automatic t_disable();
        m.status(8'hff);
        m.measure(8'h5c);
        bus(1'b0, 8'h04, 8'h00, 4'h1);
        `CHK("imp", 8'h5c, rq)
        `CHK("irq_oe_s", 1'h1, irqoe_s)
        bus(1'b0, 8'h08, 8'h00, 4'h1);
        `CHK("status", 8'hff, rq)
        bus(1'b1, 8'h18, 8'h01, 4'h1);
        repeat (2) @(posedge clk_i);
        `CHK("sw_off", 16'h0000, sw)
        `CHK("lowc", 1'h1, lowc)
        `CHK("irq_oe_clr", 1'h0, irqoe_s)
        bus(1'b0, 8'h04, 8'h00, 4'h1);
        `CHK("imp_clr", 8'h00, rq)
        bus(1'b0, 8'h08, 8'h00, 4'h1);
        `CHK("stat_clr", 8'h30, rq)
        bus(1'b0, 8'h18, 8'h00, 4'h1);
        `CHK("ctrl_rb", 8'h01, rq)
        bus(1'b1, 8'h18, 8'h11, 4'h1);
        repeat (2) @(posedge clk_i);
        `CHK("restart", 1'h1, rstp)
        settle();
        `CHK("reenable", 16'hc930, sw)
        `CHK("reenable_s", 16'h8909, sw_s)
        `CHK("lowc_off", 1'h0, lowc)
    endtask
    task automatic t_unplug();
        m.unplug();
        repeat (4) @(posedge clk_i);
        `CHK("mic", 2'h0, {sw.sb1_to_mic, sw.sb2_to_mic})
        `CHK("sb_gnd", 2'h3, {sw.sb1_to_gnd, sw.sb2_to_gnd})
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_routes();
        t_sm_orient();
        t_manual();
        t_disable();
        t_unplug();
        report_and_stop();
    end
endmodule

// ==== test/tcas_router_sva.sv ====
module tcas_router_sva
    import tcas_pkg::*;
#(
    parameter bit          SINGLE_SENSE = 1'b0,
    parameter int unsigned BBM_CYC   = 4,
    parameter int unsigned DISCH_CYC = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  avs_response_o,
    input wire logic        cc_high_i,
    input wire tcas_sw_s    switch_o,
    input wire logic        low_current_o,
    input wire logic        sm_restart_o,
    input wire logic        irq_n_o,
    input wire logic        irq_event_i,
    input wire logic        irq_n_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence ctrl_wr;
        avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h18 && avs_byteenable_i[0];
    endsequence
    // cc high may ground the sidebands at once, so cycles with cc_high_i are left out of the gap check
    sequence sw_opened;
        (|($past(switch_o) & ~switch_o)) && !cc_high_i;
    endsequence
    off_when_low_a: assert property (low_current_o |-> switch_o == 16'h0)
        else $error("switch closed while disabled");
    dis_open_a: assert property (ctrl_wr ##0 !avs_writedata_i[4] |-> ##[1:2] switch_o == 16'h0)
        else $error("switches not opened on disable");
    dis_low_a: assert property (ctrl_wr ##0 !avs_writedata_i[4] |-> ##[1:2] low_current_o)
        else $error("low current not entered");
    wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    ack_next_a: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("request not answered next cycle");
    unmapped_rd_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h00
        |-> avs_response_o == 2'h2 && avs_readdata_o == 32'h0)
        else $error("unmapped read not refused");
    bbm_gap_a: assert property (sw_opened |-> ((switch_o & ~$past(switch_o)) == 16'h0) [*4])
        else $error("switch closed too soon after break");
    restart_a: assert property (low_current_o ##0 ctrl_wr ##0 avs_writedata_i[4]
        |-> ##[1:3] sm_restart_o)
        else $error("no restart on enable");
    cc_mic_a: assert property ($rose(cc_high_i) |-> ##[1:16] !switch_o.sb1_to_mic && !switch_o.sb2_to_mic)
        else $error("mic kept on removal");
    irq_low_a: assert property (!irq_n_o)
        else $error("interrupt level not low");
    irq_ev_a: assert property (irq_event_i |=> irq_n_oe_o == SINGLE_SENSE)
        else $error("interrupt pin not pulled on event");
endmodule

bind tcas_router tcas_router_sva #(.SINGLE_SENSE(SINGLE_SENSE), .BBM_CYC(BBM_CYC),
    .DISCH_CYC(DISCH_CYC)) u_sva (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .cc_high_i(cc_high_i), .switch_o(switch_o), .low_current_o(low_current_o),
    .sm_restart_o(sm_restart_o), .irq_n_o(irq_n_o), .irq_event_i(irq_event_i),
    .irq_n_oe_o(irq_n_oe_o));

// ==== verilog/tcas_params.svh ====
`ifndef TCAS_PARAMS_SVH
`define TCAS_PARAMS_SVH

// register indices; the byte address on the avalon bus is the index times four
`define TCAS_IDX_IMPEDANCE   8'h01
`define TCAS_IDX_STATUS     8'h02
`define TCAS_IDX_CTRL       8'h06
`define TCAS_IDX_DETCFG     8'h07
`define TCAS_IDX_MANUAL_A   8'h0d
`define TCAS_IDX_MANUAL_B   8'h0e
`define TCAS_IDX_DETIN      8'h10

// control register 0x06 fields
`define TCAS_CTRL_EN_BIT    4
`define TCAS_CTRL_ROUTE_MSB 2
`define TCAS_CTRL_RESET     8'h10

// detection config register fields and status keep mask
`define TCAS_DET_CHKDIS_BIT 1
`define TCAS_DET_CONV_LSB   2
`define TCAS_DET_RESET      8'h0c
`define TCAS_STATUS_KEEP    8'h30

// timing
`define TCAS_CLK_HZ         40000000
`define TCAS_BBM_NS         10000
`define TCAS_BBM_CYC        ((`TCAS_BBM_NS * (`TCAS_CLK_HZ / 1000000)) / 1000)
`define TCAS_DISCH_NS       50000
`define TCAS_DISCH_CYC      ((`TCAS_DISCH_NS * (`TCAS_CLK_HZ / 1000000)) / 1000)

`endif

// ==== verilog/tcas_pkg.sv ====
package tcas_pkg;

    typedef enum logic [2:0] {
        TCAS_R_OFF, TCAS_R_ON_A, TCAS_R_ON_B, TCAS_R_MANUAL,
        TCAS_R_UART, TCAS_R_USB, TCAS_R_AUD_DUAL, TCAS_R_AUD_SINGLE
    } tcas_route_e;

    // one bit per analog switch; high means closed
    typedef struct packed {
        logic top_to_host1;
        logic bot_to_host2;
        logic top_to_audio;
        logic bot_to_audio;
        logic sb1_to_mic;
        logic sb1_to_gnd;
        logic sb2_to_mic;
        logic sb2_to_gnd;
        logic lmg_to_lsense;
        logic rmg_to_rsense;
        logic lgm_to_lsense;
        logic rgm_to_rsense;
        logic rmg_to_tx;
        logic rmg_to_rx;
        logic rgm_to_tx;
        logic rgm_to_rx;
    } tcas_sw_s;

    typedef enum logic [1:0] {
        TCAS_ST_IDLE, TCAS_ST_BREAK, TCAS_ST_MAKE
    } tcas_seq_e;

endpackage

// ==== verilog/tcas_router.sv ====
// Summary of operation
// RULE1: switches stay open until device is enabled
// RULE2: host sets or clears enable bit 0x06[4]
// RULE3: enable bit reads one after reset
// RULE4: enabled switches follow route field 0x06[2:0]
// RULE5: route 000 opens every connector switch
// RULE6: dual route 001 data, sb1 mic, gm sense
// RULE7: dual route 010 data, sb2 mic, mg sense
// RULE8: dual route 011 uses manual registers 0x0D/0x0E
// RULE9: dual route 100 data, rmg and lgm sense
// RULE10: dual route 101 closes only data paths
// RULE11: route 110 audio, orientation picks sense
// RULE12: route 111 like 110, right sense open; single variant keeps right sense closed on 111 as on 110
// RULE13: orientation follows plug flag when check off
// RULE14: single route 001 top data, serial sense
// RULE15: single route 101 bottom data, swapped serial
// RULE16: disabled opens all switches, low current
// RULE17: disable clears impedance code and status bits; code keeps status bits under mask 0x30
// RULE18: enable rising restarts startup state machine
// RULE19: cc high drops mic, grounds sidebands 50us
// RULE20: single variant drives open-drain irq_n low
// RULE21: break old path 10us before new path
// RULE22: new control acts after write completes
// RULE23: single routes 010/011 default, 110/111 audio
//
// The Avalon-MM slave port was decided locally.
`include "tcas_params.svh"

module tcas_router
    import tcas_pkg::*;
#(
    parameter bit          SINGLE_SENSE = 1'b0,
    parameter int unsigned BBM_CYC      = `TCAS_BBM_CYC,
    parameter int unsigned DISCH_CYC    = `TCAS_DISCH_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [1:0]  avs_response_o,
    input  wire logic        cc_high_i,
    input  wire logic        plug_orientation_flag_i,
    input  wire logic        sm_orientation_i,
    input  wire logic [7:0]  impedance_code_i,
    input  wire logic        impedance_valid_i,
    input  wire logic [7:0]  status_event_i,
    input  wire logic        irq_event_i,
    output tcas_sw_s         switch_o,
    output logic             low_current_o,
    output logic             sm_restart_o,
    output logic             irq_n_o,
    output logic             irq_n_oe_o
);

    logic [7:0] ctrl_reg;
    logic [7:0] detcfg_reg;
    logic [7:0] manual_a_reg;
    logic [7:0] manual_b_reg;
    logic [7:0] impedance_reg;
    logic [7:0] status_reg;
    logic       ack_reg;
    logic       irq_pend_reg;
    logic       en_prev_reg;
    tcas_sw_s   target;
    tcas_sw_s   applied_reg;
    tcas_seq_e  seq_reg;
    logic [15:0] bbm_cnt_reg;
    logic [15:0] disch_cnt_reg;
    logic       disch_reg;

    wire        enabled   = ctrl_reg[`TCAS_CTRL_EN_BIT];
    wire [2:0]  route_sel = ctrl_reg[`TCAS_CTRL_ROUTE_MSB:0];
    wire        wr_req    = avs_write_i && !ack_reg;
    wire        rd_req    = avs_read_i && !ack_reg;

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] idx);
        return a == {idx[5:0], 2'b00};
    endfunction

    // audio orientation: state machine choice only when the check is on and the conv field is 11, else plug flag
    wire use_plug = detcfg_reg[`TCAS_DET_CHKDIS_BIT] ||
                    (detcfg_reg[`TCAS_DET_CONV_LSB +: 2] != 2'b11); // RULE13
    wire orient   = use_plug ? plug_orientation_flag_i : sm_orientation_i; // RULE13

    // single-cycle wait state: write lands at the edge after waitrequest drops
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg     <= `TCAS_CTRL_RESET; // RULE3
            detcfg_reg   <= `TCAS_DET_RESET;
            manual_a_reg <= 8'h00;
            manual_b_reg <= 8'h00;
        end else if (avs_write_i && ack_reg && avs_byteenable_i[0]) begin // RULE22
            if (is_addr(avs_address_i, `TCAS_IDX_CTRL))
                ctrl_reg <= avs_writedata_i[7:0]; // RULE2
            if (is_addr(avs_address_i, `TCAS_IDX_DETCFG))
                detcfg_reg <= avs_writedata_i[7:0];
            if (is_addr(avs_address_i, `TCAS_IDX_MANUAL_A))
                manual_a_reg <= avs_writedata_i[7:0];
            if (is_addr(avs_address_i, `TCAS_IDX_MANUAL_B))
                manual_b_reg <= avs_writedata_i[7:0];
        end
    end

    // detection results captured from the detector; while disabled impedance clears and status keeps only bits 0x30
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            impedance_reg <= 8'h00;
            status_reg    <= 8'h00;
        end else if (!enabled) begin
            impedance_reg <= 8'h00; // RULE17
            status_reg    <= status_reg & `TCAS_STATUS_KEEP; // RULE17
        end else begin
            if (impedance_valid_i)
                impedance_reg <= impedance_code_i;
            status_reg <= status_event_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
            avs_response_o <= 2'b00;
        end else if (rd_req) begin
            avs_response_o <= 2'b00;
            if (is_addr(avs_address_i, `TCAS_IDX_IMPEDANCE))
                avs_readdata_o <= {24'h00_0000, impedance_reg};
            else if (is_addr(avs_address_i, `TCAS_IDX_STATUS))
                avs_readdata_o <= {24'h00_0000, status_reg};
            else if (is_addr(avs_address_i, `TCAS_IDX_CTRL))
                avs_readdata_o <= {24'h00_0000, ctrl_reg};
            else if (is_addr(avs_address_i, `TCAS_IDX_DETCFG))
                avs_readdata_o <= {24'h00_0000, detcfg_reg};
            else if (is_addr(avs_address_i, `TCAS_IDX_MANUAL_A))
                avs_readdata_o <= {24'h00_0000, manual_a_reg};
            else if (is_addr(avs_address_i, `TCAS_IDX_MANUAL_B))
                avs_readdata_o <= {24'h00_0000, manual_b_reg};
            else if (is_addr(avs_address_i, `TCAS_IDX_DETIN))
                avs_readdata_o <= {24'h00_0000, 3'b000, seq_reg == TCAS_ST_IDLE,
                                   disch_reg, orient, cc_high_i,
                                   plug_orientation_flag_i};
            else begin
                avs_readdata_o <= 32'h0000_0000;
                avs_response_o <= 2'b10;
            end
        end else if (wr_req) begin
            avs_response_o <= 2'b00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            avs_waitrequest_o <= 1'b1;
        else
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_reg);
    end

    // route table
    always_comb begin
        target = '0;
        if (enabled) begin // RULE1 RULE16
            case (tcas_route_e'(route_sel)) // RULE4
                TCAS_R_OFF: target = '0; // RULE5
                TCAS_R_ON_A: begin
                    target.top_to_host1 = 1'b1;
                    target.bot_to_host2 = !SINGLE_SENSE; // RULE14
                    target.sb1_to_mic   = 1'b1; // RULE6
                    target.sb2_to_gnd   = 1'b1;
                    if (SINGLE_SENSE) begin
                        target.rmg_to_tx = 1'b1; // RULE14
                        target.rgm_to_rx = 1'b1;
                    end else begin
                        target.lgm_to_lsense = 1'b1; // RULE6
                        target.rgm_to_rsense = 1'b1;
                    end
                end
                TCAS_R_ON_B, TCAS_R_MANUAL: begin
                    if (SINGLE_SENSE)
                        target = '0; // RULE23
                    else if (route_sel[0])
                        target = tcas_sw_s'({manual_b_reg, manual_a_reg}); // RULE8
                    else begin
                        target.top_to_host1  = 1'b1; // RULE7
                        target.bot_to_host2  = 1'b1;
                        target.sb1_to_gnd    = 1'b1;
                        target.sb2_to_mic    = 1'b1;
                        target.lmg_to_lsense = 1'b1;
                        target.rmg_to_rsense = 1'b1;
                    end
                end
                TCAS_R_UART: begin
                    target.top_to_host1 = 1'b1;
                    target.bot_to_host2 = !SINGLE_SENSE;
                    if (SINGLE_SENSE) begin
                        target.rmg_to_tx = !plug_orientation_flag_i;
                        target.rgm_to_rx = !plug_orientation_flag_i;
                        target.rmg_to_rx = plug_orientation_flag_i;
                        target.rgm_to_tx = plug_orientation_flag_i;
                    end else begin
                        target.rmg_to_rsense = 1'b1; // RULE9
                        target.lgm_to_lsense = 1'b1;
                    end
                end
                TCAS_R_USB: begin
                    target.top_to_host1 = !SINGLE_SENSE; // RULE10
                    target.bot_to_host2 = 1'b1; // RULE15
                    if (SINGLE_SENSE) begin
                        target.rmg_to_tx = !plug_orientation_flag_i; // RULE15
                        target.rgm_to_rx = !plug_orientation_flag_i;
                        target.rmg_to_rx = plug_orientation_flag_i;
                        target.rgm_to_tx = plug_orientation_flag_i;
                    end
                end
                TCAS_R_AUD_DUAL, TCAS_R_AUD_SINGLE: begin
                    target.top_to_audio = 1'b1; // RULE11
                    target.bot_to_audio = 1'b1;
                    target.sb1_to_mic   = !orient;
                    target.sb2_to_gnd   = !orient;
                    target.sb1_to_gnd   = orient;
                    target.sb2_to_mic   = orient;
                    if (SINGLE_SENSE) begin
                        target.rgm_to_rsense = !orient; // RULE23
                        target.rmg_to_rsense = orient;
                    end else begin
                        target.lgm_to_lsense = !orient; // RULE11
                        target.lmg_to_lsense = orient;
                        target.rgm_to_rsense = !orient && !route_sel[0]; // RULE12
                        target.rmg_to_rsense = orient && !route_sel[0]; // RULE12
                    end
                end
                default: target = '0;
            endcase
        end
    end

    // break-before-make: open dropped paths at once, close new ones after delay
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            applied_reg <= '0; // RULE1
            seq_reg     <= TCAS_ST_IDLE;
            bbm_cnt_reg <= 16'h0000;
        end else begin
            case (seq_reg)
                TCAS_ST_IDLE: begin
                    if (target != applied_reg) begin
                        applied_reg <= applied_reg & target; // RULE21
                        if ((target & ~applied_reg) != '0) begin
                            seq_reg     <= TCAS_ST_BREAK;
                            bbm_cnt_reg <= 16'(BBM_CYC);
                        end
                    end
                end
                TCAS_ST_BREAK: begin
                    applied_reg <= applied_reg & target;
                    // a further opening restarts the gap, so no close follows it early
                    if ((applied_reg & ~target) != '0)
                        bbm_cnt_reg <= 16'(BBM_CYC); // RULE21
                    else if (bbm_cnt_reg <= 16'h0001)
                        seq_reg <= TCAS_ST_MAKE;
                    else
                        bbm_cnt_reg <= bbm_cnt_reg - 16'h0001; // RULE21
                end
                TCAS_ST_MAKE: begin
                    if ((applied_reg & ~target) != '0) begin
                        applied_reg <= applied_reg & target; // RULE21
                        bbm_cnt_reg <= 16'(BBM_CYC);
                        seq_reg     <= TCAS_ST_BREAK;
                    end else begin
                        applied_reg <= target;
                        seq_reg     <= TCAS_ST_IDLE;
                    end
                end
                default: seq_reg <= TCAS_ST_IDLE;
            endcase
        end
    end

    // cc high: hold sidebands on ground; count keeps discharge asserted
    // for the full window even if cc bounces low again
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            disch_reg     <= 1'b0;
            disch_cnt_reg <= 16'h0000;
        end else if (cc_high_i && enabled) begin
            disch_reg     <= 1'b1; // RULE19
            disch_cnt_reg <= 16'(DISCH_CYC);
        end else if (disch_cnt_reg != 16'h0000) begin
            disch_cnt_reg <= disch_cnt_reg - 16'h0001;
        end else begin
            disch_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            switch_o <= '0;
        end else if (!enabled) begin
            switch_o <= '0; // RULE16
        end else begin
            switch_o <= applied_reg;
            if (disch_reg || cc_high_i) begin
                switch_o.sb1_to_mic <= 1'b0; // RULE19
                switch_o.sb2_to_mic <= 1'b0;
                switch_o.sb1_to_gnd <= 1'b1;
                switch_o.sb2_to_gnd <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_current_o <= 1'b0;
            en_prev_reg   <= 1'b1;
            sm_restart_o  <= 1'b1;
        end else begin
            low_current_o <= !enabled; // RULE16
            en_prev_reg   <= enabled;
            sm_restart_o  <= enabled && !en_prev_reg; // RULE18
        end
    end

    // open drain: only ever drives low
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_pend_reg <= 1'b0;
            irq_n_oe_o   <= 1'b0;
            irq_n_o      <= 1'b0;
        end else begin
            if (irq_event_i)
                irq_pend_reg <= 1'b1;
            else if (avs_read_i && ack_reg && is_addr(avs_address_i, `TCAS_IDX_STATUS))
                irq_pend_reg <= 1'b0;
            irq_n_o    <= 1'b0;
            irq_n_oe_o <= SINGLE_SENSE && (irq_pend_reg || irq_event_i); // RULE20
        end
    end

endmodule
